// ==== inc/tpcp_pkg.sv ====
// constants for the timing polarity and first custom pulse block
`default_nettype none
package tpcp_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_TIMING_OUTPUT_POLARITY = 8'h56;
  localparam logic [7:0] IDX_CUSTOM_LINE_PULSE_BEGIN = 8'h57;
  localparam logic [7:0] IDX_CUSTOM_LINE_PULSE_END = 8'h58;
  localparam logic [7:0] IDX_CUSTOM_FRAME_PULSE_BEGIN_LINE = 8'h59;
  localparam logic [7:0] IDX_CUSTOM_FRAME_PULSE_END_LINE = 8'h5a;
  localparam logic [7:0] IDX_CUSTOM_A_OPERATOR = 8'h5b;
  localparam logic [7:0] IDX_CUSTOM_A_STATUS = 8'h60;

  localparam int APB_ADDR_W = 10;
  localparam int REG_W = 16;
  localparam int PIX_W = 16;
  localparam int LINE_W = 15;

  // polarity register fields
  localparam int POL_LINE_SYNC_BIT = 0;
  localparam int POL_LINE_BLANK_BIT = 1;
  localparam int POL_FRAME_SYNC_BIT = 2;
  localparam logic [15:0] POL_WRITE_MASK = 16'h0007;
  localparam logic [15:0] POL_RESET = 16'h0000;

  // operator register fields
  localparam int OP_XOR_BIT = 0;
  localparam int OP_OR_BIT = 1;
  localparam int OP_AND_BIT = 2;
  localparam int OP_POLARITY_BIT = 3;
  localparam logic [15:0] OP_WRITE_MASK = 16'h000f;
  localparam logic [15:0] OP_RESET = 16'h0008;

  // window registers
  localparam logic [15:0] LINE_PULSE_RESET = 16'h0000;
  localparam logic [15:0] FRAME_LINE_WRITE_MASK = 16'h7fff;
  localparam logic [15:0] FRAME_LINE_RESET = 16'h0000;

  // status register fields
  localparam int ST_LINE_PULSE_BIT = 0;
  localparam int ST_FRAME_PULSE_BIT = 1;
  localparam int ST_COMBINED_BIT = 2;
  localparam int ST_ODD_FIELD_BIT = 3;
endpackage : tpcp_pkg
`default_nettype wire

// ==== hw/tpcp_timing.sv ====
// output polarity control and first custom timing signal, with apb registers
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// (R1) bit 2 inverts frame sync, default active low
// (R2) bit 1 inverts line blanking, default high outside video
// (R3) bit 0 inverts line sync, default active low
// (R4) 16-bit line pulse begin pixel, reset zero
// (R5) 16-bit line pulse end pixel, reset zero
// (R6) software keeps begin pixel below end pixel
// (R7) software keeps end pixel within line length
// (R8) bits 14:0 give frame pulse begin line
// (R9) bits 14:0 give frame pulse end line
// (R10) interlaced: lines counted as odd field lines
// (R11) software keeps begin line below end line
// (R12) software keeps end line within field length
// (R13) software writes zero to reserved bit 15
// (R14) custom output active low unless polarity cleared
// (R15) combine pulses: and over or over xor
// (R16) pulses active while counters inside windows
module tpcp_timing (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [tpcp_pkg::APB_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // counters and raw timing from the timing engine, active high
  input wire logic [tpcp_pkg::PIX_W-1:0] pixel_count_in,
  input wire logic [tpcp_pkg::LINE_W-1:0] frame_line_in,
  input wire logic [tpcp_pkg::LINE_W-1:0] field_line_in,
  input wire logic interlaced_in,
  input wire logic odd_field_in,
  input wire logic line_sync_active_in,
  input wire logic line_video_valid_in,
  input wire logic frame_sync_active_in,
  // timing outputs to downstream equipment
  output logic line_sync_out,
  output logic line_blank_out,
  output logic frame_sync_out,
  output logic custom_a_out
);
  import tpcp_pkg::*;

  // register file
  logic [REG_W-1:0] polarity_r;
  logic [REG_W-1:0] line_begin_r;
  logic [REG_W-1:0] line_end_r;
  logic [REG_W-1:0] frame_begin_r;
  logic [REG_W-1:0] frame_end_r;
  logic [REG_W-1:0] operator_r;
  logic [REG_W-1:0] polarity_nxt;
  logic [REG_W-1:0] line_begin_nxt;
  logic [REG_W-1:0] line_end_nxt;
  logic [REG_W-1:0] frame_begin_nxt;
  logic [REG_W-1:0] frame_end_nxt;
  logic [REG_W-1:0] operator_nxt;

  // output stage
  logic line_sync_r;
  logic line_blank_r;
  logic frame_sync_r;
  logic custom_a_r;
  logic custom_a_line_pulse_r;
  logic custom_a_frame_pulse_r;
  logic combined_r;
  logic odd_field_r;
  logic [31:0] prdata_r;

  // bus decode
  wire [7:0] reg_index = paddr_in[APB_ADDR_W-1:2];
  wire access_phase = psel_in & penable_in;
  wire bus_done = access_phase & ce_in;
  wire hit_pol = (reg_index == IDX_TIMING_OUTPUT_POLARITY);
  wire hit_lbeg = (reg_index == IDX_CUSTOM_LINE_PULSE_BEGIN);
  wire hit_lend = (reg_index == IDX_CUSTOM_LINE_PULSE_END);
  wire hit_fbeg = (reg_index == IDX_CUSTOM_FRAME_PULSE_BEGIN_LINE);
  wire hit_fend = (reg_index == IDX_CUSTOM_FRAME_PULSE_END_LINE);
  wire hit_op = (reg_index == IDX_CUSTOM_A_OPERATOR);
  wire hit_status = (reg_index == IDX_CUSTOM_A_STATUS);
  wire hit_rw = hit_pol | hit_lbeg | hit_lend | hit_fbeg | hit_fend | hit_op;
  wire hit_any = hit_rw | hit_status;
  // misaligned byte offsets are treated as unmapped
  wire addr_ok = hit_any & (paddr_in[1:0] == 2'b00);
  // status is read only, so a write to it is refused
  wire wr_ok = addr_ok & hit_rw;
  wire wr_en = bus_done & pwrite_in & wr_ok;
  wire rd_en = bus_done & ~pwrite_in;

  // byte lanes; only the low two lanes hold data
  wire [15:0] lane_mask = {{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};
  wire [15:0] wdata16 = pwdata_in[15:0];

  function automatic logic [15:0] merge(input logic [15:0] old_v,
                                        input logic [15:0] new_v,
                                        input logic [15:0] lanes,
                                        input logic [15:0] keep);
    merge = ((old_v & ~lanes) | (new_v & lanes)) & keep;
  endfunction : merge

  assign polarity_nxt = (wr_en & hit_pol) ?
                        merge(polarity_r, wdata16, lane_mask, POL_WRITE_MASK) :
                        polarity_r;
  assign line_begin_nxt = (wr_en & hit_lbeg) ?
                          merge(line_begin_r, wdata16, lane_mask, 16'hffff) :
                          line_begin_r; // R4
  assign line_end_nxt = (wr_en & hit_lend) ?
                        merge(line_end_r, wdata16, lane_mask, 16'hffff) :
                        line_end_r; // R5
  // reserved bit 15 is held at zero whatever software writes
  assign frame_begin_nxt = (wr_en & hit_fbeg) ?
                           merge(frame_begin_r, wdata16, lane_mask,
                                 FRAME_LINE_WRITE_MASK) :
                           frame_begin_r; // R8
  assign frame_end_nxt = (wr_en & hit_fend) ?
                         merge(frame_end_r, wdata16, lane_mask,
                               FRAME_LINE_WRITE_MASK) :
                         frame_end_r; // R9
  assign operator_nxt = (wr_en & hit_op) ?
                        merge(operator_r, wdata16, lane_mask, OP_WRITE_MASK) :
                        operator_r;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      polarity_r <= POL_RESET;
    end else if (ce_in) begin
      polarity_r <= polarity_nxt;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      line_begin_r <= LINE_PULSE_RESET;
    end else if (ce_in) begin
      line_begin_r <= line_begin_nxt;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      line_end_r <= LINE_PULSE_RESET;
    end else if (ce_in) begin
      line_end_r <= line_end_nxt;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      frame_begin_r <= FRAME_LINE_RESET;
    end else if (ce_in) begin
      frame_begin_r <= frame_begin_nxt;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      frame_end_r <= FRAME_LINE_RESET;
    end else if (ce_in) begin
      frame_end_r <= frame_end_nxt;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      operator_r <= OP_RESET;
    end else if (ce_in) begin
      operator_r <= operator_nxt;
    end
  end

  // read mux
  wire [15:0] status_word = {12'h000,
                             odd_field_r,
                             combined_r,
                             custom_a_frame_pulse_r,
                             custom_a_line_pulse_r};
  wire [15:0] rd_word = hit_pol ? polarity_r :
                        hit_lbeg ? line_begin_r :
                        hit_lend ? line_end_r :
                        hit_fbeg ? frame_begin_r :
                        hit_fend ? frame_end_r :
                        hit_op ? operator_r :
                        hit_status ? status_word :
                        16'h0000;
  wire [31:0] rd_next = (rd_en & addr_ok) ? {16'h0000, rd_word} : 32'h0000_0000;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      prdata_r <= 32'h0000_0000;
    end else if (ce_in) begin
      prdata_r <= rd_next;
    end
  end

  // zero-wait answer combinationally; read data comes from the access cycle
  // itself, so prdata is driven from the decode and registered copy is kept
  // only to show the last read word for one enabled cycle after the transfer, then zero
  assign pready_out = ce_in;
  assign pslverr_out = access_phase & ~(pwrite_in ? wr_ok : addr_ok);
  assign prdata_out = (access_phase & ~pwrite_in & addr_ok) ?
                      {16'h0000, rd_word} : prdata_r;

  // window detection
  // vertical values count odd field lines, so in interlaced mode the
  // field-relative counter is compared in either field
  wire [LINE_W-1:0] line_for_window = interlaced_in ? field_line_in :
                                      frame_line_in; // R10
  wire [LINE_W-1:0] frame_begin_line = frame_begin_r[LINE_W-1:0];
  wire [LINE_W-1:0] frame_end_line = frame_end_r[LINE_W-1:0];
  // begin is inclusive, end exclusive, so begin == end gives no pulse
  wire line_window = (pixel_count_in >= line_begin_r) &
                     (pixel_count_in < line_end_r); // R16
  wire frame_window = (line_for_window >= frame_begin_line) &
                      (line_for_window < frame_end_line); // R16

  // operator priority: and, then or, then xor; none set gives inactive
  wire op_and = operator_r[OP_AND_BIT];
  wire op_or = operator_r[OP_OR_BIT];
  wire op_xor = operator_r[OP_XOR_BIT];
  wire combined_active = op_and ? (line_window & frame_window) :
                         op_or ? (line_window | frame_window) :
                         op_xor ? (line_window ^ frame_window) :
                         1'b0; // R15
  // polarity bit set means active low
  wire custom_a_level = operator_r[OP_POLARITY_BIT] ? ~combined_active :
                        combined_active; // R14

  // polarity of the standard timing outputs
  wire line_sync_level = ~line_sync_active_in ^
                         polarity_r[POL_LINE_SYNC_BIT]; // R3
  wire line_blank_level = ~line_video_valid_in ^
                          polarity_r[POL_LINE_BLANK_BIT]; // R2
  wire frame_sync_level = ~frame_sync_active_in ^
                          polarity_r[POL_FRAME_SYNC_BIT]; // R1

  // every timing output is registered so all four share one cycle of latency
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      line_sync_r <= 1'b1;
    end else if (ce_in) begin
      line_sync_r <= line_sync_level;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      line_blank_r <= 1'b1;
    end else if (ce_in) begin
      line_blank_r <= line_blank_level;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      frame_sync_r <= 1'b1;
    end else if (ce_in) begin
      frame_sync_r <= frame_sync_level;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      custom_a_r <= 1'b1;
    end else if (ce_in) begin
      custom_a_r <= custom_a_level;
    end
  end

  // window and field copies below feed only the status word
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      custom_a_line_pulse_r <= 1'b0;
    end else if (ce_in) begin
      custom_a_line_pulse_r <= line_window;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      custom_a_frame_pulse_r <= 1'b0;
    end else if (ce_in) begin
      custom_a_frame_pulse_r <= frame_window;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      combined_r <= 1'b0;
    end else if (ce_in) begin
      combined_r <= combined_active;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      odd_field_r <= 1'b0;
    end else if (ce_in) begin
      odd_field_r <= odd_field_in;
    end
  end

  assign line_sync_out = line_sync_r;
  assign line_blank_out = line_blank_r;
  assign frame_sync_out = frame_sync_r;
  assign custom_a_out = custom_a_r;
endmodule : tpcp_timing
`default_nettype wire

// ==== testbench/tpcp_assertions.sv ====
// port-level assertions for the polarity and custom pulse block
`timescale 1ns/100ps
`default_nettype none
module tpcp_assertions
  import tpcp_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [tpcp_pkg::APB_ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic pslverr_out,
  input wire logic line_sync_active_in,
  input wire logic line_video_valid_in,
  input wire logic frame_sync_active_in,
  input wire logic line_sync_out,
  input wire logic line_blank_out,
  input wire logic frame_sync_out,
  input wire logic custom_a_out
);
  logic [2:0] pol_r;
  wire acc = psel_in && penable_in && ce_in;
  wire pol_wr = acc && pwrite_in && pstrb_in[0] && paddr_in == 10'h158;
  wire rd_acc = psel_in && penable_in && !pwrite_in;
  // shadow of the polarity bits, since the checker sees only ports
  always_ff @(posedge clock_in) begin
    if (rst_in) pol_r <= 3'h0;
    else if (pol_wr) pol_r <= pwdata_in[2:0];
  end
  default clocking cb @(posedge clock_in); endclocking
  property p_line_sync;
    disable iff (rst_in) ce_in && !rst_in |=> line_sync_out == (~$past(line_sync_active_in) ^ $past(pol_r[0]));
  endproperty
  a_line_sync: assert property (p_line_sync) else $error("line sync level wrong");
  property p_line_blank;
    disable iff (rst_in) ce_in && !rst_in |=> line_blank_out == (~$past(line_video_valid_in) ^ $past(pol_r[1]));
  endproperty
  a_line_blank: assert property (p_line_blank) else $error("line blank level wrong");
  property p_frame_sync;
    disable iff (rst_in) ce_in && !rst_in |=> frame_sync_out == (~$past(frame_sync_active_in) ^ $past(pol_r[2]));
  endproperty
  a_frame_sync: assert property (p_frame_sync) else $error("frame sync level wrong");
  property p_pol_read;
    disable iff (rst_in) rd_acc && paddr_in == 10'h158 |-> prdata_out == {29'h0, pol_r};
  endproperty
  a_pol_read: assert property (p_pol_read) else $error("polarity readback wrong");
  property p_reset_idle;
    rst_in |=> line_sync_out && line_blank_out && frame_sync_out && custom_a_out;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
  property p_freeze;
    disable iff (rst_in) !ce_in |=> $stable(custom_a_out) && $stable(line_sync_out);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
  property p_begin_line;
    disable iff (rst_in) rd_acc && paddr_in == 10'h164 |-> prdata_out[31:15] == 17'h0_0000;
  endproperty
  a_begin_line: assert property (p_begin_line) else $error("begin line upper bits set");
  property p_end_line;
    disable iff (rst_in) rd_acc && paddr_in == 10'h168 |-> prdata_out[31:15] == 17'h0_0000;
  endproperty
  a_end_line: assert property (p_end_line) else $error("end line upper bits set");
  c_custom_fall: cover property (disable iff (rst_in) $fell(custom_a_out));
  c_slverr: cover property (disable iff (rst_in) acc && pslverr_out);
  c_frozen: cover property (disable iff (rst_in) !ce_in);
endmodule : tpcp_assertions
bind tpcp_timing tpcp_assertions u_chk (.clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
  .pslverr_out(pslverr_out), .line_sync_active_in(line_sync_active_in),
  .line_video_valid_in(line_video_valid_in), .frame_sync_active_in(frame_sync_active_in),
  .line_sync_out(line_sync_out), .line_blank_out(line_blank_out),
  .frame_sync_out(frame_sync_out), .custom_a_out(custom_a_out));
`default_nettype wire

// ==== testbench/tpcp_sink.sv ====
// downstream consumer model: counts falling edges of the custom signal
`timescale 1ns/100ps
`default_nettype none
module tpcp_sink (
  input wire logic level_in,
  output logic [15:0] falls_out
);
  // default active low, so a fall marks the start of a pulse
  initial begin
    falls_out = 16'h0000;
    forever @(negedge level_in) falls_out <= falls_out + 16'h0001;
  end
endmodule : tpcp_sink
`default_nettype wire

// ==== testbench/tpcp_timing_tb_top.sv ====
// self-checking bench for the polarity and custom pulse block
`timescale 1ns/100ps
`default_nettype none
module tpcp_timing_tb_top;
  import tpcp_pkg::*;
  logic clock_in = 0, rst_in = 1, ce_in = 1, psel = 0, pen = 0, pwr = 0, e, pe, ex, h0;
  logic pready, perr, interl = 0, odd = 0, hs = 0, vv = 0, vs = 0, lso, lbo, fso, cao;
  logic [9:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, d;
  logic [15:0] pix = 0, falls, f0, nf;
  logic [14:0] fl = 0, fdl = 0, ln;
  logic [3:0] ops [6] = '{4'h8, 4'h9, 4'ha, 4'hc, 4'hf, 4'h2};
  int err_total = 0, cmp_count = 0, seed = 2727;
  always #4 clock_in = ~clock_in;
  tpcp_timing dut (.clock_in(clock_in), .rst_in(rst_in), .ce_in(ce_in), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hf),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr), .pixel_count_in(pix),
    .frame_line_in(fl), .field_line_in(fdl), .interlaced_in(interl), .odd_field_in(odd),
    .line_sync_active_in(hs), .line_video_valid_in(vv), .frame_sync_active_in(vs),
    .line_sync_out(lso), .line_blank_out(lbo), .frame_sync_out(fso), .custom_a_out(cao));
  tpcp_sink sink (.level_in(cao), .falls_out(falls));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] v);
    @(posedge clock_in);
    psel <= 1;
    pwr <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clock_in);
    pen <= 1;
    do @(posedge clock_in); while (pready !== 1'b1);
    rd = prdata;
    e = perr;
    psel <= 0;
    pen <= 0;
  endtask : apb
  task automatic step();
    @(posedge clock_in);
    {hs, vv, vs, interl, odd} <= 5'($random(seed));
    pix <= 16'($random(seed)) & 16'h003f;
    fl <= 15'($random(seed)) & 15'h001f;
    fdl <= 15'($random(seed)) & 15'h001f;
    @(posedge clock_in);
    #1;
  endtask : step
  function automatic logic [31:0] msk(input int i);
    return i == 0 ? 32'h0000_0007 : i < 3 ? 32'h0000_ffff : 32'h0000_7fff;
  endfunction : msk
  function automatic logic cust(input logic [15:0] p, input logic [14:0] l, input logic [3:0] op);
    logic h, v, c;
    h = 16'h0008 <= p && p < 16'h0028;
    v = 15'h0004 <= l && l < 15'h0014;
    c = op[2] ? h & v : op[1] ? h | v : op[0] & (h ^ v);
    return op[3] ? ~c : c;
  endfunction : cust
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    #400000;
    err_total++;
    tally_and_finish();
  end
  initial begin
    repeat (6) @(posedge clock_in);
    rst_in <= 0;
    for (int i = 0; i < 6; i++) begin
      apb(0, 10'h158 + 10'(4 * i), 0);
      chk(rd, i == 5 ? 32'h0000_0008 : 32'h0000_0000);
    end
    for (int i = 0; i < 5; i++) begin
      d = $random(seed);
      // reserved bit 15 of the frame line registers is written as zero
      if (i > 2) d = d & 32'h0000_7fff;
      apb(1, 10'h158 + 10'(4 * i), d);
      apb(0, 10'h158 + 10'(4 * i), 0);
      chk(rd, d & msk(i));
    end
    apb(0, 10'h3fc, 0);
    chk(rd, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    for (int p = 0; p < 8; p++) begin
      apb(1, 10'h158, p);
      repeat (4) begin
        step();
        chk(lso, {31'h0, ~hs ^ p[0]});
        chk(lbo, {31'h0, ~vv ^ p[1]});
        chk(fso, {31'h0, ~vs ^ p[2]});
      end
    end
    // freeze: outputs keep their level and the bus holds off
    // polarity is left at 3'h7 by the loop above
    h0 = ~hs ^ 1'b1;
    @(posedge clock_in);
    ce_in <= 0;
    hs <= ~hs;
    repeat (2) @(posedge clock_in);
    #1;
    chk(lso, h0);
    chk(pready, 0);
    @(posedge clock_in);
    ce_in <= 1;
    @(posedge clock_in);
    #1;
    chk(lso, {31'h0, ~hs ^ 1'b1});
    // windows sit inside a 64-pixel line and a 32-line field
    apb(1, 10'h15c, 8);
    apb(1, 10'h160, 40);
    apb(1, 10'h164, 4);
    apb(1, 10'h168, 20);
    foreach (ops[k]) begin
      apb(1, 10'h16c, ops[k]);
      nf = 0;
      for (int n = 0; n < 40; n++) begin
        step();
        ex = cust(pix, interl ? fdl : fl, ops[k]);
        chk(cao, ex);
        if (n == 0) f0 = falls;
        else if (pe && !ex) nf++;
        pe = ex;
      end
      chk(falls - f0, nf);
    end
    // status: odd field, combined (or, active high), frame window, line window
    ln = interl ? fdl : fl;
    ex = cust(pix, 15'h0004, 4'h4);
    pe = cust(16'h0008, ln, 4'h4);
    apb(0, 10'h180, 0);
    chk(rd, {28'h0, odd, cust(pix, ln, 4'h2), pe, ex});
    tally_and_finish();
  end
endmodule : tpcp_timing_tb_top
`default_nettype wire
